// ### hdl/uacore_consts.svh
// Register offsets, field positions and reset values of the serial core
`ifndef UACORE_CONSTS_SVH
`define UACORE_CONSTS_SVH

`define UACORE_ADDR_MODE 16'hFF50
`define UACORE_ADDR_BAUD 16'hFF51
`define UACORE_ADDR_STAT 16'hFF53
`define UACORE_ADDR_RXBUF 16'hFF54
`define UACORE_ADDR_TXDATA 16'hFF55

`define UACORE_MODE_POWER 7
`define UACORE_MODE_TXEN 6
`define UACORE_MODE_RXEN 5
`define UACORE_MODE_PS_HI 4
`define UACORE_MODE_PS_LO 3
`define UACORE_MODE_CL 2
`define UACORE_MODE_SL 1

`define UACORE_STAT_PE 2
`define UACORE_STAT_FE 1
`define UACORE_STAT_OVE 0

`define UACORE_RST_MODE 8'h01
`define UACORE_RST_BAUD 5'h1F
`define UACORE_RST_RXBUF 8'hFF
`define UACORE_RST_TXDATA 8'hFF
`define UACORE_RST_STAT 3'h0

`define UACORE_DIV_MIN 5'h08
`define UACORE_LAST_BIT8 3'h7
`define UACORE_LAST_BIT7 3'h6

`endif

// ### hdl/uacore_pkg.sv
// Types shared by the serial core modules
package uacore_pkg;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP  = 3'b100
   } uacore_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } uacore_rx_state_t;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD  = 2'b10,
      PAR_EVEN = 2'b11
   } uacore_parity_t;

endpackage

// ### hdl/uacore_baud_div.sv
// Divide-by-k counter giving one tick per k base clocks
`timescale 1ns/1ps
module uacore_baud_div #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic [W-1:0] k,
   output logic tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic [W-1:0] k_m1;

   assign k_m1 = k - W'(1);
   assign tick = !clr && (cnt_r == k_m1);

   always_comb begin
      if (clr || cnt_r == k_m1) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ### hdl/uacore_top.sv
// Asynchronous serial transceiver core with its mode and data registers
//
// How it works
// - Each completed character is copied into the 8-bit receive buffer unless it overruns.
// - With 7-bit characters the buffer holds bits 0-6 and bit 7 reads 0.
// - On overrun the new character is dropped and the buffer keeps old data.
// - Receive buffer is read-only and all ones after reset or power-off.
// - Writing transmit data starts a frame; that register cannot be read.
// - Transmit data is all ones after reset, power-off or transmit disable.
// - Power bit low resets the core and forces the receive input high.
// - Transmit enable low disables and synchronously resets the transmitter.
// - Receive enable low disables and synchronously resets the receiver.
// - Parity field: none, forced zero, odd or even, sent and checked.
// - In zero-parity mode the parity error flag is never raised.
// - Length bit picks 7 data bits when 0 and 8 when 1, both ways.
// - Stop-bit bit sets one or two stop bits on transmit only.
// - Enabling reception with the input already low starts a reception.
// - Enables act on the base clock; re-enable no sooner than two clocks.
// - Mode register resets to 0x01; software always writes bit 0 as one.
// - Error status clears on reset, power-off or receive disable.
// - Framing, parity and overrun errors are flagged at character end.
// - Bit time is two divider periods, divisor k from 8 to 31 clocks.
// - Data bits go out and come in least significant bit first.
`timescale 1ns/1ps
`include "uacore_consts.svh"
module uacore_top
   import uacore_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [15:0] ADDR,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   input wire logic SERIAL_IN_LINE,
   output logic SERIAL_OUT_LINE,
   output logic TRANSMIT_DONE_IRQ,
   output logic RX_DONE,
   output logic RX_ERROR
);
   logic [7:0] mode_r, mode_nxt;
   logic [4:0] baud_r, baud_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic core_rst;
   logic power_on, txe, rxe, cl, sl;
   uacore_parity_t par_mode;
   logic [4:0] div_k;
   logic [2:0] last_bit;

   assign power_on = mode_r[`UACORE_MODE_POWER];
   assign txe = mode_r[`UACORE_MODE_TXEN];
   assign rxe = mode_r[`UACORE_MODE_RXEN];
   assign cl = mode_r[`UACORE_MODE_CL];
   assign sl = mode_r[`UACORE_MODE_SL];
   assign par_mode = uacore_parity_t'(
      {mode_r[`UACORE_MODE_PS_HI], mode_r[`UACORE_MODE_PS_LO]});
   // Power-off acts as an asynchronous reset of everything but the controls and read port
   assign core_rst = SYS_RST || !power_on;
   // Prohibited divisors below the minimum are clamped rather than honoured
   assign div_k = (baud_r < `UACORE_DIV_MIN) ? `UACORE_DIV_MIN
                                             : baud_r;
   assign last_bit = cl ? `UACORE_LAST_BIT8 : `UACORE_LAST_BIT7;

   logic wr_mode, wr_baud, wr_tx, rd_stat, rd_buf;
   assign wr_mode = WR_STB && ADDR == `UACORE_ADDR_MODE;
   assign wr_baud = WR_STB && ADDR == `UACORE_ADDR_BAUD;
   assign wr_tx = WR_STB && ADDR == `UACORE_ADDR_TXDATA;
   assign rd_stat = RD_STB && ADDR == `UACORE_ADDR_STAT;
   assign rd_buf = RD_STB && ADDR == `UACORE_ADDR_RXBUF;

   // Serial input synchroniser; power-off presents an idle-high line
   logic rx_meta_r, rx_sync_r, rx_line;
   always_ff @(posedge CLK or posedge core_rst) begin
      if (core_rst) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= SERIAL_IN_LINE;
         rx_sync_r <= rx_meta_r;
      end
   end
   assign rx_line = power_on ? rx_sync_r : 1'b1;

   // Transmitter
   uacore_tx_state_t tx_state_r, tx_state_nxt;
   logic [7:0] tx_shift_r, tx_shift_nxt;
   logic [2:0] tx_cnt_r, tx_cnt_nxt;
   logic tx_phase_r, tx_phase_nxt, tx_par_r, tx_par_nxt;
   logic tx_stop2_r, tx_stop2_nxt, tx_line_r, tx_line_nxt;
   logic tx_done_r, tx_done_nxt, tx_div_clr, tx_tick, tx_adv;

   uacore_baud_div #(.W(5)) u_tx_div (
      .clk(CLK),
      .rst(core_rst),
      .clr(tx_div_clr),
      .k(div_k),
      .tick(tx_tick)
   );

   // One bit lasts two divider ticks
   assign tx_adv = tx_tick && tx_phase_r;

   always_comb begin
      tx_state_nxt = tx_state_r;
      tx_shift_nxt = tx_shift_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_phase_nxt = tx_phase_r;
      tx_par_nxt = tx_par_r;
      tx_stop2_nxt = tx_stop2_r;
      tx_line_nxt = tx_line_r;
      tx_done_nxt = 1'b0;
      tx_div_clr = 1'b0;
      if (!txe) begin
         tx_state_nxt = TX_IDLE;
         tx_shift_nxt = `UACORE_RST_TXDATA;
         tx_cnt_nxt = 3'h0;
         tx_phase_nxt = 1'b0;
         tx_stop2_nxt = 1'b0;
         tx_line_nxt = 1'b1;
         tx_div_clr = 1'b1;
      end else begin
         if (tx_tick) begin
            tx_phase_nxt = !tx_phase_r;
         end
         unique case (tx_state_r)
            TX_IDLE: begin
               tx_div_clr = 1'b1;
               tx_phase_nxt = 1'b0;
               tx_line_nxt = 1'b1;
               // Writes outside idle are ignored; software paces on done
               if (wr_tx) begin
                  tx_shift_nxt = WDATA;
                  tx_state_nxt = TX_START;
                  tx_line_nxt = 1'b0;
                  tx_cnt_nxt = 3'h0;
                  tx_par_nxt = 1'b0;
               end
            end
            TX_START: begin
               if (tx_adv) begin
                  tx_state_nxt = TX_DATA;
                  tx_line_nxt = tx_shift_r[0];
                  tx_par_nxt = tx_shift_r[0];
                  tx_shift_nxt = {1'b1, tx_shift_r[7:1]};
               end
            end
            TX_DATA: begin
               if (tx_adv) begin
                  if (tx_cnt_r == last_bit) begin
                     if (par_mode == PAR_NONE) begin
                        tx_state_nxt = TX_STOP;
                        tx_line_nxt = 1'b1;
                        tx_stop2_nxt = sl;
                     end else begin
                        tx_state_nxt = TX_PAR;
                        unique case (par_mode)
                           PAR_ZERO: tx_line_nxt = 1'b0;
                           PAR_ODD: tx_line_nxt = !tx_par_r;
                           PAR_EVEN: tx_line_nxt = tx_par_r;
                           PAR_NONE: tx_line_nxt = 1'b1;
                        endcase
                     end
                  end else begin
                     tx_cnt_nxt = tx_cnt_r + 3'h1;
                     tx_line_nxt = tx_shift_r[0];
                     tx_par_nxt = tx_par_r ^ tx_shift_r[0];
                     tx_shift_nxt = {1'b1, tx_shift_r[7:1]};
                  end
               end
            end
            TX_PAR: begin
               if (tx_adv) begin
                  tx_state_nxt = TX_STOP;
                  tx_line_nxt = 1'b1;
                  tx_stop2_nxt = sl;
               end
            end
            TX_STOP: begin
               if (tx_adv) begin
                  if (tx_stop2_r) begin
                     tx_stop2_nxt = 1'b0;
                  end else begin
                     tx_state_nxt = TX_IDLE;
                     tx_done_nxt = 1'b1;
                  end
               end
            end
            default: begin
               tx_state_nxt = TX_IDLE;
               tx_line_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge core_rst) begin
      if (core_rst) begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= `UACORE_RST_TXDATA;
         tx_cnt_r <= 3'h0;
         tx_phase_r <= 1'b0;
         tx_par_r <= 1'b0;
         tx_stop2_r <= 1'b0;
         tx_line_r <= 1'b1;
         tx_done_r <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         tx_shift_r <= tx_shift_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_phase_r <= tx_phase_nxt;
         tx_par_r <= tx_par_nxt;
         tx_stop2_r <= tx_stop2_nxt;
         tx_line_r <= tx_line_nxt;
         tx_done_r <= tx_done_nxt;
      end
   end

   // Receiver
   uacore_rx_state_t rx_state_r, rx_state_nxt;
   logic [7:0] rx_shift_r, rx_shift_nxt, rxbuf_r, rxbuf_nxt, rx_data;
   logic [2:0] rx_cnt_r, rx_cnt_nxt, stat_r, stat_nxt;
   logic rx_phase_r, rx_phase_nxt, rx_par_r, rx_par_nxt;
   logic rx_perr_r, rx_perr_nxt, rx_full_r, rx_full_nxt;
   logic rx_done_r, rx_done_nxt, rx_err_r, rx_err_nxt;
   logic rx_div_clr, rx_tick, rx_smp, rx_fe, rx_ove;

   uacore_baud_div #(.W(5)) u_rx_div (
      .clk(CLK),
      .rst(core_rst),
      .clr(rx_div_clr),
      .k(div_k),
      .tick(rx_tick)
   );

   // Samples fall mid-bit: half a bit after the start edge, then every bit
   assign rx_smp = rx_tick && rx_phase_r;
   assign rx_data = cl ? rx_shift_r : {1'b0, rx_shift_r[7:1]};
   assign rx_fe = !rx_line;
   assign rx_ove = rx_full_r && !rd_buf;

   always_comb begin
      rx_state_nxt = rx_state_r;
      rx_shift_nxt = rx_shift_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_phase_nxt = rx_phase_r;
      rx_par_nxt = rx_par_r;
      rx_perr_nxt = rx_perr_r;
      rx_full_nxt = rx_full_r;
      rxbuf_nxt = rxbuf_r;
      stat_nxt = stat_r;
      rx_done_nxt = 1'b0;
      rx_err_nxt = 1'b0;
      rx_div_clr = 1'b0;
      if (!rxe) begin
         rx_state_nxt = RX_IDLE;
         rx_phase_nxt = 1'b0;
         rx_full_nxt = 1'b0;
         stat_nxt = `UACORE_RST_STAT;
         rx_div_clr = 1'b1;
      end else begin
         // Clears by software first, so a same-cycle event still lands
         if (rd_stat) begin
            stat_nxt = `UACORE_RST_STAT;
         end
         if (rd_buf) begin
            rx_full_nxt = 1'b0;
         end
         if (rx_tick) begin
            rx_phase_nxt = !rx_phase_r;
         end
         unique case (rx_state_r)
            RX_IDLE: begin
               rx_div_clr = 1'b1;
               // Level, not edge: a line already low when enabled starts
               if (!rx_line) begin
                  rx_state_nxt = RX_START;
                  rx_phase_nxt = 1'b1;
               end else begin
                  rx_phase_nxt = 1'b0;
               end
            end
            RX_START: begin
               if (rx_smp) begin
                  if (rx_line) begin
                     rx_state_nxt = RX_IDLE;
                  end else begin
                     rx_state_nxt = RX_DATA;
                     rx_cnt_nxt = 3'h0;
                     rx_par_nxt = 1'b0;
                     rx_perr_nxt = 1'b0;
                     rx_shift_nxt = 8'h00;
                  end
               end
            end
            RX_DATA: begin
               if (rx_smp) begin
                  rx_shift_nxt = {rx_line, rx_shift_r[7:1]};
                  rx_par_nxt = rx_par_r ^ rx_line;
                  if (rx_cnt_r == last_bit) begin
                     rx_state_nxt = (par_mode == PAR_NONE) ? RX_STOP
                                                           : RX_PAR;
                  end else begin
                     rx_cnt_nxt = rx_cnt_r + 3'h1;
                  end
               end
            end
            RX_PAR: begin
               if (rx_smp) begin
                  rx_state_nxt = RX_STOP;
                  unique case (par_mode)
                     PAR_ODD: rx_perr_nxt = !(rx_par_r ^ rx_line);
                     PAR_EVEN: rx_perr_nxt = rx_par_r ^ rx_line;
                     PAR_ZERO: rx_perr_nxt = 1'b0;
                     PAR_NONE: rx_perr_nxt = 1'b0;
                  endcase
               end
            end
            RX_STOP: begin
               // Only the first stop bit is checked
               if (rx_smp) begin
                  rx_state_nxt = RX_IDLE;
                  rx_done_nxt = 1'b1;
                  if (rx_ove) begin
                     stat_nxt[`UACORE_STAT_OVE] = 1'b1;
                  end else begin
                     rxbuf_nxt = rx_data;
                     rx_full_nxt = 1'b1;
                  end
                  if (rx_fe) begin
                     stat_nxt[`UACORE_STAT_FE] = 1'b1;
                  end
                  if (rx_perr_r) begin
                     stat_nxt[`UACORE_STAT_PE] = 1'b1;
                  end
                  rx_err_nxt = rx_ove || rx_fe || rx_perr_r;
               end
            end
            default: begin
               rx_state_nxt = RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge core_rst) begin
      if (core_rst) begin
         rx_state_r <= RX_IDLE;
         rx_shift_r <= 8'h00;
         rx_cnt_r <= 3'h0;
         rx_phase_r <= 1'b0;
         rx_par_r <= 1'b0;
         rx_perr_r <= 1'b0;
         rx_full_r <= 1'b0;
         rxbuf_r <= `UACORE_RST_RXBUF;
         stat_r <= `UACORE_RST_STAT;
         rx_done_r <= 1'b0;
         rx_err_r <= 1'b0;
      end else begin
         rx_state_r <= rx_state_nxt;
         rx_shift_r <= rx_shift_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_phase_r <= rx_phase_nxt;
         rx_par_r <= rx_par_nxt;
         rx_perr_r <= rx_perr_nxt;
         rx_full_r <= rx_full_nxt;
         rxbuf_r <= rxbuf_nxt;
         stat_r <= stat_nxt;
         rx_done_r <= rx_done_nxt;
         rx_err_r <= rx_err_nxt;
      end
   end

   // Control registers and read port survive power-off
   always_comb begin
      mode_nxt = wr_mode ? WDATA : mode_r;
      baud_nxt = wr_baud ? WDATA[4:0] : baud_r;
      rdata_nxt = rdata_r;
      if (RD_STB) begin
         unique case (ADDR)
            `UACORE_ADDR_MODE: rdata_nxt = mode_r;
            `UACORE_ADDR_BAUD: rdata_nxt = {3'h0, baud_r};
            `UACORE_ADDR_STAT: rdata_nxt = {5'h00, stat_r};
            `UACORE_ADDR_RXBUF: rdata_nxt = rxbuf_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_r <= `UACORE_RST_MODE;
         baud_r <= `UACORE_RST_BAUD;
         rdata_r <= 8'h00;
      end else begin
         mode_r <= mode_nxt;
         baud_r <= baud_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign SERIAL_OUT_LINE = tx_line_r;
   assign TRANSMIT_DONE_IRQ = tx_done_r;
   assign RX_DONE = rx_done_r;
   assign RX_ERROR = rx_err_r;
endmodule

// ### tb/uacore_chk.sv
// Port-level assertions for the serial core, bound to its top module
`timescale 1ns/1ps
`include "uacore_consts.svh"
module uacore_chk (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [15:0] ADDR,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] RDATA,
   input wire logic SERIAL_IN_LINE,
   input wire logic SERIAL_OUT_LINE,
   input wire logic TRANSMIT_DONE_IRQ,
   input wire logic RX_DONE,
   input wire logic RX_ERROR
);
   // Mode shadow rebuilt from writes, as only the ports are visible here
   logic [7:0] mode_r;
   logic busy_r;
   logic got_r;
   logic tx_go;
   logic rd_buf;
   logic mode_wr;
   assign mode_wr = WR_STB && ADDR == `UACORE_ADDR_MODE;
   assign rd_buf = RD_STB && ADDR == `UACORE_ADDR_RXBUF;
   assign tx_go = WR_STB && ADDR == `UACORE_ADDR_TXDATA && mode_r[7] &&
      mode_r[6] && !busy_r;
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mode_r <= `UACORE_RST_MODE;
         busy_r <= 1'h0;
         got_r <= 1'h0;
      end else begin
         if (mode_wr) begin
            mode_r <= WDATA;
         end
         if (tx_go) begin
            busy_r <= 1'h1;
         end else if (TRANSMIT_DONE_IRQ || !mode_r[7] || !mode_r[6]) begin
            busy_r <= 1'h0;
         end
         // A format change may leave a char of the other length behind
         got_r <= !mode_wr && (got_r || RX_DONE);
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   a_tx_start:
   assert property (tx_go |=> !SERIAL_OUT_LINE [*8])
      else $error("no start bit after transmit write");
   a_idle_high:
   assert property (!busy_r |-> SERIAL_OUT_LINE)
      else $error("line low outside a frame");
   a_done_bound:
   assert property (tx_go |-> ##[100:1000] TRANSMIT_DONE_IRQ)
      else $error("transmit done pulse missing");
   a_rx_err_pair:
   assert property (RX_ERROR |-> RX_DONE)
      else $error("error pulse without receive done");
   a_rd_hold:
   assert property (!RD_STB |=> $stable(RDATA))
      else $error("read data changed without a read");
   a_tx_unread:
   assert property (RD_STB && ADDR == `UACORE_ADDR_TXDATA |=> RDATA == 8'h00)
      else $error("transmit data was readable");
   a_buf_off:
   assert property (rd_buf && !mode_r[7] |=> RDATA == 8'hFF)
      else $error("buffer not all ones while powered off");
   a_stat_clr:
   assert property (RD_STB && ADDR == `UACORE_ADDR_STAT &&
      !(mode_r[7] && mode_r[5]) |=> RDATA == 8'h00)
      else $error("status not clear while receive off");
   a_buf_msb7:
   assert property (rd_buf && got_r && !mode_r[2] |=> !RDATA[7])
      else $error("buffer top bit set in short mode");
   a_mode_rd:
   assert property (RD_STB && ADDR == `UACORE_ADDR_MODE |=>
      RDATA == $past(mode_r))
      else $error("mode readback differs from last write");
endmodule

bind uacore_top uacore_chk chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
   .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA), .RDATA(RDATA),
   .SERIAL_IN_LINE(SERIAL_IN_LINE), .SERIAL_OUT_LINE(SERIAL_OUT_LINE),
   .TRANSMIT_DONE_IRQ(TRANSMIT_DONE_IRQ), .RX_DONE(RX_DONE),
   .RX_ERROR(RX_ERROR));

// ### tb/uacore_remote.sv
// Remote serial station: frame sender and frame decoder
`timescale 1ns/1ps
module uacore_remote
   import uacore_pkg::*;
(
   input wire logic clk,
   input wire logic line_in,
   output logic line_out,
   input wire integer bit_cyc,
   input wire integer nb,
   input wire logic par_on,
   input wire logic two_stop
);
   int got_q[$];
   initial line_out = 1'h1;
   task automatic send(input logic [7:0] d, input logic [1:0] pm,
      input logic bad_par, input logic bad_stop);
      logic [7:0] m;
      logic p;
      m = nb == 8 ? d : {1'h0, d[6:0]};
      p = pm == PAR_ZERO ? 1'h0 : (pm == PAR_ODD ? ~^m : ^m);
      @(posedge clk) line_out <= 1'h0;
      repeat (bit_cyc) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         line_out <= m[i];
         repeat (bit_cyc) @(posedge clk);
      end
      if (pm != PAR_NONE) begin
         line_out <= p ^ bad_par;
         repeat (bit_cyc) @(posedge clk);
      end
      // One stop bit only: the receiver must not need a second one
      line_out <= !bad_stop;
      repeat (bit_cyc) @(posedge clk);
      line_out <= 1'h1;
   endtask
   // Samples each bit at its middle and packs data, parity and stops
   always begin
      int f;
      f = 0;
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < nb + par_on + 1 + two_stop; i++) begin
         repeat (bit_cyc) @(posedge clk);
         f[i] = line_in;
      end
      got_q.push_back(f);
   end
endmodule

// ### tb/tb.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`include "uacore_consts.svh"
module tb
   import uacore_pkg::*;
;
   logic CLK = 1'h0;
   logic SYS_RST = 1'h1;
   logic [15:0] ADDR = 16'h0000;
   logic WR_STB = 1'h0;
   logic RD_STB = 1'h0;
   logic [7:0] WDATA = 8'h00;
   logic [7:0] RDATA;
   logic rx_line;
   logic tx_line;
   logic TRANSMIT_DONE_IRQ;
   logic RX_DONE;
   logic RX_ERROR;
   int err_count = 0;
   int check_count = 0;
   int bc = 16;
   int nbv = 8;
   logic pon = 1'h0;
   logic two = 1'h0;
   logic [1:0] pmv = 2'h0;
   logic [7:0] fmt [4] = '{8'h05, 8'h0B, 8'h15, 8'h19};
   int kv [4] = '{8, 8, 12, 9};
   always #12.5 CLK = ~CLK;
   uacore_top dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
      .WR_STB(WR_STB), .RD_STB(RD_STB), .WDATA(WDATA), .RDATA(RDATA),
      .SERIAL_IN_LINE(rx_line), .SERIAL_OUT_LINE(tx_line),
      .TRANSMIT_DONE_IRQ(TRANSMIT_DONE_IRQ), .RX_DONE(RX_DONE),
      .RX_ERROR(RX_ERROR));
   uacore_remote rem_u (.clk(CLK), .line_in(tx_line), .line_out(rx_line),
      .bit_cyc(bc), .nb(nbv), .par_on(pon), .two_stop(two));
   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR_STB <= 1'h1;
      @(posedge CLK);
      WR_STB <= 1'h0;
   endtask
   task automatic rdc(input string n, input logic [15:0] a,
      input logic [7:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD_STB <= 1'h1;
      @(posedge CLK);
      RD_STB <= 1'h0;
      @(negedge CLK);
      chk(n, {8'h00, e}, {8'h00, RDATA});
   endtask
   function automatic logic [7:0] msk(input logic [7:0] d);
      return nbv == 8 ? d : {1'h0, d[6:0]};
   endfunction
   // Enables drop before the format changes, then come back together
   task automatic cfg(input int i);
      wr(`UACORE_ADDR_MODE, 8'h81);
      wr(`UACORE_ADDR_MODE, 8'h80 | fmt[i]);
      wr(`UACORE_ADDR_BAUD, kv[i][7:0]);
      bc = 2 * kv[i];
      nbv = fmt[i][2] ? 8 : 7;
      pmv = fmt[i][4:3];
      pon = pmv != PAR_NONE;
      two = fmt[i][1];
      wr(`UACORE_ADDR_MODE, 8'hE0 | fmt[i]);
      repeat (2) @(posedge CLK);
   endtask
   task automatic tx_one(input logic [7:0] d);
      int c;
      int f;
      int n;
      int e;
      logic p;
      c = 0;
      p = pmv == PAR_ZERO ? 1'h0 : (pmv == PAR_ODD ? ~^msk(d) : ^msk(d));
      e = msk(d);
      if (pon) e = e | (p << nbv);
      e = e | ((two ? 3 : 1) << (nbv + pon));
      n = (2 + nbv + pon + two) * bc;
      wr(`UACORE_ADDR_TXDATA, d);
      do begin
         @(negedge CLK);
         c++;
      end while (TRANSMIT_DONE_IRQ !== 1'h1 && c < 4000);
      chk("tx done time", 16'h0001, 16'(c >= n && c <= n + 4));
      f = rem_u.got_q.size() > 0 ? rem_u.got_q.pop_front() : -1;
      chk("tx frame", e[15:0], f[15:0]);
   endtask
   task automatic rx_one(input logic [7:0] d, input logic bp,
      input logic bs, input logic e);
      int c;
      c = 0;
      fork
         rem_u.send(d, pmv, bp, bs);
         begin
            do begin
               @(negedge CLK);
               c++;
            end while (RX_DONE !== 1'h1 && c < 4000);
            chk("rx done", 16'h0001, {15'h0000, RX_DONE});
            chk("rx error", {15'h0000, e}, {15'h0000, RX_ERROR});
         end
      join
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK);
      err_count++;
      results();
   end
   initial begin
      logic [7:0] d;
      logic [7:0] d1;
      void'($urandom(12637));
      repeat (10) @(posedge CLK);
      SYS_RST <= 1'h0;
      rdc("mode reset", `UACORE_ADDR_MODE, 8'h01);
      rdc("baud reset", `UACORE_ADDR_BAUD, 8'h1F);
      rdc("status reset", `UACORE_ADDR_STAT, 8'h00);
      rdc("buffer reset", `UACORE_ADDR_RXBUF, 8'hFF);
      rdc("tx data read", `UACORE_ADDR_TXDATA, 8'h00);
      wr(`UACORE_ADDR_RXBUF, 8'h00);
      rdc("buffer write", `UACORE_ADDR_RXBUF, 8'hFF);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         cfg(i);
         tx_one(8'($urandom));
         d = 8'($urandom);
         rx_one(d, pmv == PAR_ZERO, 1'h0, 1'h0);
         rdc("rx status", `UACORE_ADDR_STAT, 8'h00);
         rdc("rx buffer", `UACORE_ADDR_RXBUF, msk(d));
         $display("test format %0d done", i);
      end
      cfg(2);
      d = 8'($urandom);
      d1 = 8'($urandom);
      rx_one(d, 1'h1, 1'h0, 1'h1);
      rdc("parity flag", `UACORE_ADDR_STAT, 8'h04);
      rdc("parity data", `UACORE_ADDR_RXBUF, d);
      rx_one(d, 1'h0, 1'h1, 1'h1);
      rdc("framing flag", `UACORE_ADDR_STAT, 8'h02);
      rdc("framing data", `UACORE_ADDR_RXBUF, d);
      rx_one(d1, 1'h0, 1'h0, 1'h0);
      rx_one(d, 1'h0, 1'h0, 1'h1);
      rdc("overrun flag", `UACORE_ADDR_STAT, 8'h01);
      rdc("overrun data", `UACORE_ADDR_RXBUF, d1);
      $display("test errors done");
      rx_one(d, 1'h1, 1'h0, 1'h1);
      wr(`UACORE_ADDR_MODE, 8'h80 | fmt[2]);
      rdc("rx off status", `UACORE_ADDR_STAT, 8'h00);
      wr(`UACORE_ADDR_TXDATA, d);
      repeat (400) @(negedge CLK);
      chk("tx disabled", 16'h0000, 16'(rem_u.got_q.size()));
      wr(`UACORE_ADDR_MODE, 8'h01);
      rdc("off buffer", `UACORE_ADDR_RXBUF, 8'hFF);
      rdc("off status", `UACORE_ADDR_STAT, 8'h00);
      rdc("off mode", `UACORE_ADDR_MODE, 8'h01);
      $display("test disable done");
      results();
   end
endmodule
